/* File: pkg/operand_address_gen_params.svh */
`ifndef OPERAND_ADDRESS_GEN_PARAMS_SVH
`define OPERAND_ADDRESS_GEN_PARAMS_SVH

// ==========================================
// widths and window geometry
`define OAG_DATA_W      8
`define OAG_ADDR_W      16
`define OAG_WIN_BYTES   8
`define OAG_WIN_SEL_W   3
`define OAG_PAIR_MASK   8'hfe
`define OAG_RESET_PTR   8'hc0

`endif

/* File: pkg/operand_address_gen_pkg.sv */
package operand_address_gen_pkg;

    // ==========================================
    // addressing modes
    typedef enum logic [2:0] {
        register_mode,
        working_mode,
        pointer_operand_mode,
        indexed_mode,
        long_target_mode,
        pc_offset_mode,
        literal_operand_mode
    } mode_e;

    // ==========================================
    // instruction classes that pick the target space
    typedef enum logic [2:0] {
        move_instruction,
        code_memory_load,
        data_memory_load,
        long_branch,
        call_instruction,
        short_branch,
        other_instruction
    } instr_e;

    // ==========================================
    // target spaces
    typedef enum logic [1:0] {
        space_none,
        space_register,
        space_program,
        space_external
    } space_e;

    typedef enum logic [1:0] {
        idle_st,
        pair_st
    } seq_e;

endpackage

/* File: verilog/displacement_adder.sv */
`timescale 1ns/1ps
`default_nettype none

`include "operand_address_gen_params.svh"

// ==========================================
// signed or unsigned offset added to a 16-bit base, wrapping
module displacement_adder #(
    parameter int ADDR_W = `OAG_ADDR_W
) (
    // operands
    input  wire logic [ADDR_W-1:0] base,
    input  wire logic [ADDR_W-1:0] offset,
    input  wire logic              short_signed,
    // result
    output logic      [ADDR_W-1:0] sum
);

    logic [ADDR_W-1:0] ext;

    always_comb begin
        // short offsets sign-extend from bit 7
        if (short_signed) begin
            ext = {{(ADDR_W-8){offset[7]}}, offset[7:0]};
        end else begin
            ext = offset;
        end
        sum = base + ext; // carry out dropped: modulo 2^16
    end

endmodule

`default_nettype wire

/* File: verilog/operand_address_gen.sv */
`timescale 1ns/1ps
`default_nettype none

`include "operand_address_gen_params.svh"

module operand_address_gen
    import operand_address_gen_pkg::*;
#(
    parameter int DATA_W = `OAG_DATA_W,
    parameter int ADDR_W = `OAG_ADDR_W
) (
    // clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst_b,
    // decoded instruction from execution unit
    input  wire logic                          start,
    input  wire operand_address_gen_pkg::mode_e  mode,
    input  wire operand_address_gen_pkg::instr_e instr,
    input  wire logic                          pair,
    input  wire logic                          short_offset,
    input  wire logic [DATA_W-1:0]             reg_field,
    input  wire logic [ADDR_W-1:0]             operand_field,
    input  wire logic [ADDR_W-1:0]             next_pc,
    // register pointer
    input  wire logic                          ptr_load,
    input  wire logic [DATA_W-1:0]             ptr_value,
    // register file read port
    output logic      [DATA_W-1:0]             rf_addr,
    input  wire logic [DATA_W-1:0]             rf_data,
    // results
    output logic                               done,
    output logic      [ADDR_W-1:0]             operand,
    output logic      [ADDR_W-1:0]             eff_addr,
    output operand_address_gen_pkg::space_e    space,
    output logic                               pc_load,
    output logic      [ADDR_W-1:0]             pc_value,
    output logic      [DATA_W-1:0]             reg_pointer
);

    import operand_address_gen_pkg::*;

    // ==========================================
    // state
    typedef struct packed {
        seq_e              seq;
        logic [DATA_W-1:0] ptr;
        logic [DATA_W-1:0] step_addr;
        logic [DATA_W-1:0] high;
        logic              done;
        logic [ADDR_W-1:0] operand;
        logic [ADDR_W-1:0] eff_addr;
        space_e            space;
        logic              pc_load;
        logic [ADDR_W-1:0] pc_value;
    } state_s;

    state_s cur;
    state_s next_cur;

    // ==========================================
    // helpers
    function automatic logic [DATA_W-1:0] window_addr(
        input logic [DATA_W-1:0] p,
        input logic [DATA_W-1:0] r
    );
        // window base aligned to 8 bytes, register index in the low bits
        window_addr = {p[DATA_W-1:`OAG_WIN_SEL_W], r[`OAG_WIN_SEL_W-1:0]};
    endfunction

    function automatic logic [DATA_W-1:0] even_of(input logic [DATA_W-1:0] a);
        even_of = a & `OAG_PAIR_MASK;
    endfunction

    function automatic space_e mem_space(input instr_e i);
        case (i)
            code_memory_load: mem_space = space_program;
            data_memory_load: mem_space = space_external;
            default:          mem_space = space_register;
        endcase
    endfunction

    // ==========================================
    // address path
    logic              use_window;
    logic [DATA_W-1:0] src_addr;
    logic [ADDR_W-1:0] add_base;
    logic [ADDR_W-1:0] add_off;
    logic              add_signed;
    logic [ADDR_W-1:0] add_sum;
    logic [ADDR_W-1:0] rd_word;

    // working modes pass a short register field through the window
    assign use_window = (mode == working_mode) || (mode == indexed_mode);
    assign src_addr   = use_window ? window_addr(cur.ptr, reg_field) : reg_field;
    assign rd_word    = {cur.high, rf_data};

    always_comb begin
        add_base   = '0;
        add_off    = '0;
        add_signed = 1'b0;
        if (mode == pc_offset_mode) begin
            add_base   = next_pc; // already past current instruction
            add_off    = operand_field;
            add_signed = 1'b1;
        end else if (instr == move_instruction) begin
            // base from instruction, offset from working register
            add_base = {{(ADDR_W-DATA_W){1'b0}}, operand_field[DATA_W-1:0]};
            add_off  = {{(ADDR_W-DATA_W){1'b0}}, rf_data};
        end else begin
            add_base   = rd_word; // base from working pair
            add_off    = operand_field;
            add_signed = short_offset;
        end
    end

    displacement_adder #(
        .ADDR_W (ADDR_W)
    ) u_adder (
        .base         (add_base),
        .offset       (add_off),
        .short_signed (add_signed),
        .sum          (add_sum)
    );

    // ==========================================
    // sequencer: one read for bytes, two for pairs (high then low)
    logic needs_pair;
    assign needs_pair = pair || ((mode == indexed_mode) && (instr != move_instruction));

    always_comb begin
        next_cur         = cur;
        next_cur.done    = 1'b0;
        next_cur.pc_load = 1'b0;
        rf_addr          = src_addr;
        if (ptr_load) begin
            next_cur.ptr = ptr_value;
        end
        case (cur.seq)
            idle_st: begin
                rf_addr = needs_pair ? even_of(src_addr) : src_addr;
                if (start) begin
                    next_cur.step_addr = even_of(src_addr) + 8'h01;
                    case (mode)
                        literal_operand_mode: begin
                            // no register read used at all
                            next_cur.operand  = operand_field;
                            next_cur.space    = space_none;
                            next_cur.done     = 1'b1;
                        end
                        long_target_mode: begin
                            next_cur.eff_addr = operand_field;
                            next_cur.done     = 1'b1;
                            if ((instr == long_branch) || (instr == call_instruction)) begin
                                next_cur.pc_load  = 1'b1;
                                next_cur.pc_value = operand_field;
                                next_cur.space    = space_program;
                            end else begin
                                next_cur.space = mem_space(instr);
                            end
                        end
                        pc_offset_mode: begin
                            // every instruction in this mode reaches here; only short branch loads the pc
                            next_cur.pc_load  = (instr == short_branch);
                            next_cur.pc_value = add_sum;
                            next_cur.eff_addr = add_sum;
                            next_cur.space    = space_program;
                            next_cur.done     = 1'b1;
                        end
                        default: begin
                            if (needs_pair) begin
                                next_cur.high = rf_data; // even register = msb
                                next_cur.seq  = pair_st;
                            end else begin
                                next_cur.operand = {{(ADDR_W-DATA_W){1'b0}}, rf_data};
                                next_cur.done    = 1'b1;
                                if (mode == indexed_mode) begin
                                    // move indexes the register file only
                                    next_cur.eff_addr = {{(ADDR_W-DATA_W){1'b0}},
                                                         add_sum[DATA_W-1:0]};
                                    next_cur.space    = space_register;
                                end else if (mode == pointer_operand_mode) begin
                                    // 8-bit pointer addresses a register
                                    next_cur.eff_addr = {{(ADDR_W-DATA_W){1'b0}}, rf_data};
                                    next_cur.space    = space_register;
                                end else begin
                                    next_cur.space = space_none;
                                end
                            end
                        end
                    endcase
                end
            end
            pair_st: begin
                rf_addr         = cur.step_addr; // odd register = lsb
                next_cur.seq    = idle_st;
                next_cur.done   = 1'b1;
                next_cur.operand = rd_word;
                if (mode == indexed_mode) begin
                    next_cur.eff_addr = add_sum;
                    next_cur.space    = mem_space(instr);
                end else if (mode == pointer_operand_mode) begin
                    // 16-bit pair points into memory for loads, into register space otherwise
                    next_cur.eff_addr = rd_word;
                    next_cur.space    = mem_space(instr);
                end else begin
                    next_cur.space = space_none;
                end
            end
            default: begin
                next_cur.seq = idle_st;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cur          <= '0;
            cur.seq      <= idle_st;
            cur.ptr      <= `OAG_RESET_PTR;
            cur.space    <= space_none;
        end else begin
            cur <= next_cur;
        end
    end

    // ==========================================
    // outputs
    assign done        = cur.done;
    assign operand     = cur.operand;
    assign eff_addr    = cur.eff_addr;
    assign space       = cur.space;
    assign pc_load     = cur.pc_load;
    assign pc_value    = cur.pc_value;
    assign reg_pointer = cur.ptr;

endmodule

`default_nettype wire

/* File: test/reg_file_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// register file read port, combinational
module reg_file_model (
    // read port
    input  wire logic [7:0] rf_addr,
    output logic      [7:0] rf_data
);
    // contents derived from the address so even and odd bytes differ
    assign rf_data = rf_addr ^ 8'h5a;
endmodule

`default_nettype wire

/* File: test/operand_address_gen_checker.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// port-level checks
module operand_address_gen_checker
    import operand_address_gen_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic              clock,
    input wire logic              rst_b,
    // request
    input wire logic              start,
    input wire operand_address_gen_pkg::mode_e  mode,
    input wire operand_address_gen_pkg::instr_e instr,
    input wire logic              pair,
    input wire logic [DATA_W-1:0] reg_field,
    input wire logic [ADDR_W-1:0] operand_field,
    input wire logic [ADDR_W-1:0] next_pc,
    // register file and results
    input wire logic [DATA_W-1:0] rf_addr,
    input wire logic [DATA_W-1:0] rf_data,
    input wire logic              done,
    input wire logic [ADDR_W-1:0] operand,
    input wire logic [ADDR_W-1:0] eff_addr,
    input wire operand_address_gen_pkg::space_e space,
    input wire logic              pc_load,
    input wire logic [ADDR_W-1:0] pc_value,
    input wire logic [DATA_W-1:0] reg_pointer
);
    logic [15:0] rel_exp;

    // branch target computed a cycle early, slices cannot go through past
    always_ff @(posedge clock) begin
        rel_exp <= next_pc + {{8{operand_field[7]}}, operand_field[7:0]};
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_pair_reads;
        rf_addr == (reg_field & 8'hfe) ##1 rf_addr == (reg_field | 8'h01);
    endsequence

    a_reg_byte: assert property (start && mode == register_mode && !pair |->
        rf_addr == reg_field ##1 done && operand == {8'h00, $past(rf_data)})
        else $error("register byte operand wrong");
    a_pair_order: assert property (start && pair && mode == register_mode |->
        s_pair_reads ##1 done && operand == {$past(rf_data, 2), $past(rf_data)})
        else $error("register pair order wrong");
    a_work_window: assert property (start && mode == working_mode |->
        rf_addr == {reg_pointer[7:3], reg_field[2:0]})
        else $error("working window address wrong");
    a_literal_op: assert property (start && mode == literal_operand_mode |=>
        done && operand == $past(operand_field) && space == space_none)
        else $error("immediate operand wrong");
    a_rel_target: assert property (start && mode == pc_offset_mode &&
        instr == short_branch |=> done && pc_load && pc_value == rel_exp)
        else $error("relative target wrong");
    a_long_target: assert property (start && mode == long_target_mode &&
        instr inside {long_branch, call_instruction} |=>
        pc_load && pc_value == $past(operand_field))
        else $error("direct branch target wrong");
    a_direct_load: assert property (start && mode == long_target_mode &&
        instr == data_memory_load |=> done && !pc_load &&
        eff_addr == $past(operand_field) && space == space_external)
        else $error("direct load address wrong");
    a_load_done: assert property (pc_load |-> done)
        else $error("pc load without done");
endmodule

`default_nettype wire

bind operand_address_gen operand_address_gen_checker #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_chk (
    .clock, .rst_b, .start, .mode, .instr, .pair, .reg_field, .operand_field,
    .next_pc, .rf_addr, .rf_data, .done, .operand, .eff_addr, .space, .pc_load,
    .pc_value, .reg_pointer);

/* File: test/operand_address_gen_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module operand_address_gen_tb;
    import operand_address_gen_pkg::*;
    // ==========================================
    // signals
    logic        clock, rst_b, start, pair, short_offset, ptr_load, done, pc_load;
    mode_e       mode;
    instr_e      instr;
    space_e      space;
    logic [7:0]  reg_field, ptr_value, rf_addr, rf_data, reg_pointer;
    logic [15:0] operand_field, next_pc, operand, eff_addr, pc_value, b;
    int          err_total, checked;

    operand_address_gen u_dut (.clock, .rst_b, .start, .mode, .instr, .pair,
        .short_offset, .reg_field, .operand_field, .next_pc, .ptr_load, .ptr_value,
        .rf_addr, .rf_data, .done, .operand, .eff_addr, .space, .pc_load,
        .pc_value, .reg_pointer);
    reg_file_model u_rf (.rf_addr, .rf_data);

    // ==========================================
    // helpers
    function automatic logic [7:0] rfm(input logic [7:0] a);
        return a ^ 8'h5a;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic results;
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // called at a falling edge; returns at the falling edge that shows done
    task automatic run(input mode_e m, input instr_e i, input logic p, input logic s,
                       input logic [7:0] r, input logic [15:0] op, input logic [15:0] pc);
        int n;
        // one idle edge first: start never drops and rises in one time step
        @(negedge clock);
        mode = m; instr = i; pair = p; short_offset = s;
        reg_field = r; operand_field = op; next_pc = pc; start = 1'b1;
        for (n = 0; n < 6; n++) begin
            @(negedge clock);
            start = 1'b0;
            if (done === 1'b1) break;
        end
        if (n == 6) begin
            err_total++;
            $display("mismatch at %0t: done never came", $time);
            results();
        end
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset;
        chk(reg_pointer, 8'hc0, "reset pointer");
        chk(done, 1'b0, "reset done");
        chk(space, space_none, "reset space");
        $display("test reset over");
    endtask

    task automatic t_register;
        run(register_mode, move_instruction, 0, 0, 8'h37, 0, 0);
        chk(operand, {8'h00, rfm(8'h37)}, "reg byte");
        run(register_mode, move_instruction, 1, 0, 8'h45, 0, 0);
        chk(operand, {rfm(8'h44), rfm(8'h45)}, "reg pair");
        $display("test register over");
    endtask

    task automatic t_working;
        ptr_load = 1'b1;
        ptr_value = 8'h28;
        @(negedge clock);
        ptr_load = 1'b0;
        chk(reg_pointer, 8'h28, "pointer load");
        run(working_mode, move_instruction, 0, 0, 8'hfd, 0, 0);
        chk(operand, {8'h00, rfm(8'h2d)}, "working reg");
        $display("test working over");
    endtask

    task automatic t_pointer;
        run(pointer_operand_mode, move_instruction, 0, 0, 8'h61, 0, 0);
        chk(eff_addr, {8'h00, rfm(8'h61)}, "ptr byte");
        chk(space, space_register, "ptr byte space");
        run(pointer_operand_mode, code_memory_load, 1, 0, 8'h91, 0, 0);
        chk(eff_addr, {rfm(8'h90), rfm(8'h91)}, "ptr pair");
        chk(space, space_program, "ptr code space");
        run(pointer_operand_mode, data_memory_load, 1, 0, 8'h90, 0, 0);
        chk(space, space_external, "ptr data space");
        $display("test pointer over");
    endtask

    // pointer still 8'h28 here, so the window is 8'h28..8'h2f
    task automatic t_indexed;
        run(indexed_mode, move_instruction, 0, 0, 8'h03, 16'h00f0, 0);
        chk(eff_addr, {8'h00, 8'hf0 + rfm(8'h2b)}, "index reg");
        chk(space, space_register, "index reg space");
        b = {rfm(8'h2c), rfm(8'h2d)};
        run(indexed_mode, data_memory_load, 0, 1, 8'h04, 16'h0080, 0);
        chk(eff_addr, b + 16'hff80, "index short");
        chk(space, space_external, "index data space");
        run(indexed_mode, code_memory_load, 0, 0, 8'h04, 16'h9000, 0);
        chk(eff_addr, b + 16'h9000, "index long wraps");
        chk(space, space_program, "index code space");
        $display("test indexed over");
    endtask

    task automatic t_direct;
        run(long_target_mode, long_branch, 0, 0, 0, 16'hbeef, 0);
        chk(pc_value, 16'hbeef, "jump target");
        run(long_target_mode, call_instruction, 0, 0, 0, 16'h0123, 0);
        chk(pc_load, 1'b1, "call loads pc");
        run(long_target_mode, code_memory_load, 0, 0, 0, 16'h1234, 0);
        chk(eff_addr, 16'h1234, "direct code");
        chk(space, space_program, "direct code space");
        run(long_target_mode, data_memory_load, 0, 0, 0, 16'h4321, 0);
        chk(eff_addr, 16'h4321, "direct data");
        chk(space, space_external, "direct data space");
        chk(pc_load, 1'b0, "data load keeps pc");
        $display("test direct over");
    endtask

    task automatic t_relative;
        run(pc_offset_mode, short_branch, 0, 0, 0, 16'h0080, 16'h0010);
        chk(pc_value, 16'hff90, "branch back wraps");
        run(pc_offset_mode, short_branch, 0, 0, 0, 16'h007f, 16'hfff0);
        chk(pc_value, 16'h006f, "branch forward");
        chk(pc_load, 1'b1, "branch loads pc");
        run(pc_offset_mode, other_instruction, 0, 0, 0, 16'h0005, 16'h0100);
        chk(pc_load, 1'b0, "non branch keeps pc");
        chk(eff_addr, 16'h0105, "relative address");
        $display("test relative over");
    endtask

    task automatic t_literal;
        run(literal_operand_mode, move_instruction, 0, 0, 0, 16'h00a5, 0);
        chk(operand, 16'h00a5, "immediate");
        chk(space, space_none, "immediate space");
        $display("test literal over");
    endtask

    // ==========================================
    // clock and sequence
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial begin
        rst_b = 1'b0; start = 1'b0; mode = register_mode; instr = move_instruction;
        pair = 1'b0; short_offset = 1'b0; reg_field = 8'h00; operand_field = 16'h0000;
        next_pc = 16'h0000; ptr_load = 1'b0; ptr_value = 8'h00;
        err_total = 0; checked = 0;
        repeat (10) @(negedge clock);
        t_reset();
        rst_b = 1'b1;
        t_register();
        t_working();
        t_pointer();
        t_indexed();
        t_direct();
        t_relative();
        t_literal();
        results();
    end
endmodule

`default_nettype wire
